//--- hw/dac_ctrl_regs.svh
// Function
// R1: Readback starts with write address, command byte.
// R2: Repeated start, read address, two data bytes.
// R3: Master ends readback with NACK then stop.
// R4: Multi-channel readback selection returns channel zero.
// R5: Send MSB first, advance pointer per pair.
// R6: Read pointer wraps from seven to zero.
// R7: Power command loads two bits per channel.
// R8: Modes: normal, resistor to ground, high impedance.
// R9: Power-down keeps and still updates DAC registers.
// R10: Strobe low: input and DAC on 24th clock.
// R11: Strobe high: input only, falling edge transfers.
// R12: Update command copies input, ignores strobe level.
// R13: Write-and-update loads both registers, strobe ignored.
// R14: Mask command loads low byte, ignores address.
// R15: Mask one ignores strobe, zero follows it.
// R16: Strobe falling edge transfers every unmasked channel.
// R17: Strobe held low disregards the mask bits.
// R18: Write frame: command, data MSB, data LSB.
// R19: Address: five fixed bits plus two straps.
// R20: Command 1001 arms readback of input registers.
// R21: Update command data bits select channels.
// R22: Power modes and mask clear at reset.
`ifndef DAC_CTRL_REGS_SVH
`define DAC_CTRL_REGS_SVH

// -----------------------------------------------------------------------
// Command codes and frame fields
// -----------------------------------------------------------------------
`define CMD_WRITE_INPUT  4'h1
`define CMD_UPDATE_DAC   4'h2
`define CMD_WRITE_UPDATE 4'h3
`define CMD_POWER_MODE   4'h4
`define CMD_STROBE_MASK  4'h5
`define CMD_READBACK     4'h9
`define DEV_ADDR_FIXED   5'h03
`define MODE_NORMAL      2'h0
`define MODE_RES_GND     2'h1
`define MODE_HIGH_Z      2'h3

// -----------------------------------------------------------------------
// Reset values and counts
// -----------------------------------------------------------------------
`define MASK_RESET       8'h00
`define POWER_RESET      16'h0000
`define FRAME_LAST_BYTE  2'h2
`define SYNC_STAGES      2

`endif

//--- hw/dac_ctrl_pkg.sv
`default_nettype none

`include "dac_ctrl_regs.svh"

package dac_ctrl_pkg;

  // Serial link states.
  typedef enum logic [2:0] {
    LINK_IDLE     = 3'h0,
    LINK_ADDR     = 3'h1,
    LINK_ADDR_ACK = 3'h2,
    LINK_WR_BYTE  = 3'h3,
    LINK_WR_ACK   = 3'h4,
    LINK_RD_BYTE  = 3'h5,
    LINK_RD_ACK   = 3'h6
  } link_state_t;

  // Channel power field.
  typedef enum logic [1:0] {
    PWR_NORMAL  = `MODE_NORMAL,
    PWR_RES_GND = `MODE_RES_GND,
    PWR_HIGH_Z  = `MODE_HIGH_Z
  } power_mode_t;

endpackage

`default_nettype wire

//--- hw/chan_bank_if.sv
`timescale 1ns/10ps
`default_nettype none

// Write and read path between the command logic and the register bank.
interface chan_bank_if #(
  parameter int CH = 8,
  parameter int W  = 16
);
  logic [$clog2(CH)-1:0] wr_ch;
  logic [W-1:0]          wr_data;
  logic                  wr_in;
  logic                  wr_dac;
  logic [CH-1:0]         xfer;
  logic [$clog2(CH)-1:0] rd_ch;
  logic [W-1:0]          rd_data;

  modport ctrl (output wr_ch, wr_data, wr_in, wr_dac, xfer, rd_ch, input rd_data);
  modport bank (input wr_ch, wr_data, wr_in, wr_dac, xfer, rd_ch, output rd_data);
endinterface

`default_nettype wire

//--- hw/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser per pin; only the second stage is visible.
module pin_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Pins
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync_q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      // Pins idle high after reset so no false edge is seen.
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_q        <= 1'b1;
          pin_sync_q[i] <= 1'b1;
        end else begin
          meta_q        <= pin_in[i];
          pin_sync_q[i] <= meta_q;
        end
      end
    end
  endgenerate
endmodule

`default_nettype wire

//--- hw/chan_bank.sv
`timescale 1ns/10ps
`default_nettype none

// Double-buffered channel registers: input bank and DAC bank.
module chan_bank #(
  parameter int CH = 8,
  parameter int W  = 16
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  // Command side
  chan_bank_if.bank          bus,
  // Converter side
  output logic [CH*W-1:0]    dac_value
);
  localparam int CW = $clog2(CH);

  logic [W-1:0] input_q [CH];

  assign bus.rd_data = input_q[bus.rd_ch];

  genvar i;
  generate
    for (i = 0; i < CH; i++) begin : g_ch
      logic sel;
      assign sel = (bus.wr_ch == CW'(i));
      // A direct write wins over a transfer in the same cycle; the
      // power state is not looked at, so updates land while powered down.
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          input_q[i]             <= '0;
          dac_value[i*W +: W]    <= '0;
        end else begin
          if (sel && bus.wr_in)
            input_q[i] <= bus.wr_data;
          if (sel && bus.wr_dac)
            dac_value[i*W +: W] <= bus.wr_data;             // [R9]
          else if (bus.xfer[i])
            dac_value[i*W +: W] <= input_q[i];              // [R12] [R16]
        end
      end
    end
  endgenerate
endmodule

`default_nettype wire

//--- hw/dac_link_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

`include "dac_ctrl_regs.svh"

// Two-wire slave, command decode and strobe handling of the converter.
module dac_link_ctrl #(
  parameter int CH = 8,
  parameter int W  = 16
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  // Serial link pins
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output logic               sda_out,
  output logic               sda_oe,
  // Straps and load strobe
  input  wire logic [1:0]    addr_strap,
  input  wire logic          load_strobe_n,
  // Converter side
  output logic [CH*W-1:0]    dac_value,
  output logic [2*CH-1:0]    power_modes
);

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  logic [4:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       strobe_n_s;
  logic [1:0] strap_s;

  pin_sync #(.W(5)) u_sync (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .pin_in     ({addr_strap, load_strobe_n, sda_in, scl_in}),
    .pin_sync_q (pins_s)
  );

  assign scl_s      = pins_s[0];
  assign sda_s      = pins_s[1];
  assign strobe_n_s = pins_s[2];
  assign strap_s    = pins_s[4:3];

  // ---------------------------------------------------------------------
  // Register bank
  // ---------------------------------------------------------------------
  chan_bank_if #(.CH(CH), .W(W)) bank_bus ();

  chan_bank #(.CH(CH), .W(W)) u_bank (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .bus       (bank_bus),
    .dac_value (dac_value)
  );

  // ---------------------------------------------------------------------
  // Edge detection on the synchronised pins
  // ---------------------------------------------------------------------
  logic scl_d_q;
  logic sda_d_q;
  logic strobe_d_q;

  // Delayed copies of the second synchroniser stage.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d_q    <= 1'b1;
      sda_d_q    <= 1'b1;
      strobe_d_q <= 1'b1;
    end else begin
      scl_d_q    <= scl_s;
      sda_d_q    <= sda_s;
      strobe_d_q <= strobe_n_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic strobe_fall;

  assign scl_rise    = scl_s & ~scl_d_q;
  assign scl_fall    = ~scl_s & scl_d_q;
  assign start_seen  = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign stop_seen   = scl_s & scl_d_q & ~sda_d_q & sda_s;
  assign strobe_fall = strobe_d_q & ~strobe_n_s;

  // ---------------------------------------------------------------------
  // Link state machine
  // ---------------------------------------------------------------------
  dac_ctrl_pkg::link_state_t state_q, state_d;
  logic [7:0]  shift_q;
  logic [2:0]  bit_q;
  logic [1:0]  wbyte_q;
  logic        rw_q;
  logic [7:0]  cmd_q;
  logic [7:0]  msb_q;
  logic [2:0]  rd_ptr_q;
  logic        rd_half_q;
  logic        rb_armed_q;
  logic        sda_oe_q;
  logic        sda_out_q;
  logic [7:0]  mask_q;
  logic [15:0] power_q;

  logic [7:0]  shift_in;
  logic        byte_full;
  logic        addr_match;
  logic        commit;
  logic [3:0]  cmd_code;
  logic [3:0]  cmd_chan;
  logic [15:0] frame_data;
  logic        load_rd;
  logic [7:0]  rd_byte;
  logic        rd_ack_ok;
  logic        rb_set;
  logic        ack_q;
  logic        byte_done_q;
  logic        shift_d7;

  assign shift_in   = {shift_q[6:0], sda_s};
  assign byte_full  = (bit_q == 3'h7);
  // Five fixed bits plus the two strap pins form the address.
  assign addr_match = (shift_q[7:1] == {`DEV_ADDR_FIXED, strap_s});     // [R19]
  // The third byte's eighth bit is the 24th clock after the address.
  assign commit     = (state_q == dac_ctrl_pkg::LINK_WR_BYTE) && scl_rise && byte_full
                      && (wbyte_q == `FRAME_LAST_BYTE);                  // [R10] [R18]
  assign cmd_code   = cmd_q[7:4];
  assign cmd_chan   = cmd_q[3:0];
  assign frame_data = {msb_q, shift_in};
  // The command byte alone arms readback; no data bytes follow it.
  assign rb_set     = (state_q == dac_ctrl_pkg::LINK_WR_BYTE) && scl_rise && byte_full
                      && (wbyte_q == 2'h0) && (shift_in[7:4] == `CMD_READBACK); // [R1] [R20]
  assign rd_ack_ok  = (state_q == dac_ctrl_pkg::LINK_RD_ACK) && scl_rise && ~sda_s;
  assign load_rd    = scl_fall && (((state_q == dac_ctrl_pkg::LINK_ADDR_ACK) && rw_q)
                      || ((state_q == dac_ctrl_pkg::LINK_RD_ACK) && ~sda_oe_q && ack_q));
  // High byte first, low byte second; an unarmed read returns zero.
  assign rd_byte    = ~rb_armed_q ? 8'h00 :
                      (rd_half_q ? bank_bus.rd_data[7:0] : bank_bus.rd_data[15:8]); // [R5]

  // Next state; start and stop override any bit in progress.
  always_comb begin
    state_d = state_q;
    if (start_seen)
      state_d = dac_ctrl_pkg::LINK_ADDR;
    else if (stop_seen)
      state_d = dac_ctrl_pkg::LINK_IDLE;
    else if (scl_fall) begin
      unique case (state_q)
        dac_ctrl_pkg::LINK_IDLE:     state_d = dac_ctrl_pkg::LINK_IDLE;
        dac_ctrl_pkg::LINK_ADDR:
          if (bit_q == 3'h0 && byte_done_q)
            state_d = addr_match ? dac_ctrl_pkg::LINK_ADDR_ACK : dac_ctrl_pkg::LINK_IDLE;
        dac_ctrl_pkg::LINK_ADDR_ACK:
          state_d = rw_q ? dac_ctrl_pkg::LINK_RD_BYTE : dac_ctrl_pkg::LINK_WR_BYTE;
        dac_ctrl_pkg::LINK_WR_BYTE:
          if (bit_q == 3'h0 && byte_done_q)
            state_d = dac_ctrl_pkg::LINK_WR_ACK;
        dac_ctrl_pkg::LINK_WR_ACK:   state_d = dac_ctrl_pkg::LINK_WR_BYTE;
        // The eighth falling edge ends the byte, so release for the answer here.
        dac_ctrl_pkg::LINK_RD_BYTE:
          if (byte_full)
            state_d = dac_ctrl_pkg::LINK_RD_ACK;
        dac_ctrl_pkg::LINK_RD_ACK:
          state_d = ack_q ? dac_ctrl_pkg::LINK_RD_BYTE : dac_ctrl_pkg::LINK_IDLE; // [R3]
        default:                     state_d = dac_ctrl_pkg::LINK_IDLE;
      endcase
    end
  end

  // State register.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      state_q <= dac_ctrl_pkg::LINK_IDLE;
    else
      state_q <= state_d;
  end

  logic in_rx;
  logic in_tx;
  assign in_rx = (state_q == dac_ctrl_pkg::LINK_ADDR) || (state_q == dac_ctrl_pkg::LINK_WR_BYTE);
  assign in_tx = (state_q == dac_ctrl_pkg::LINK_RD_BYTE);

  // Bit counter and shift register; received bits sample on the rising
  // edge, transmitted bits move on the falling edge.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_q     <= 8'h00;
      bit_q       <= 3'h0;
      byte_done_q <= 1'b0;
    end else if (start_seen) begin
      bit_q       <= 3'h0;
      byte_done_q <= 1'b0;
    end else if (in_rx && scl_rise) begin
      shift_q     <= shift_in;
      bit_q       <= bit_q + 3'h1;
      byte_done_q <= byte_full;
    end else if (load_rd) begin
      shift_q     <= rd_byte;
      bit_q       <= 3'h0;
      byte_done_q <= 1'b0;
    end else if (in_tx && scl_fall) begin
      shift_q     <= {shift_q[6:0], 1'b1};
      bit_q       <= bit_q + 3'h1;
      byte_done_q <= byte_full;
    end else if (scl_fall && byte_done_q) begin
      byte_done_q <= 1'b0;
    end
  end

  // Frame bookkeeping: direction, byte index and captured bytes.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rw_q    <= 1'b0;
      wbyte_q <= 2'h0;
      cmd_q   <= 8'h00;
      msb_q   <= 8'h00;
      ack_q   <= 1'b0;
    end else begin
      if (state_q == dac_ctrl_pkg::LINK_ADDR && scl_rise && byte_full)
        rw_q <= sda_s;
      if (state_q == dac_ctrl_pkg::LINK_ADDR_ACK)
        wbyte_q <= 2'h0;
      else if (state_q == dac_ctrl_pkg::LINK_WR_BYTE && scl_rise && byte_full) begin
        if (wbyte_q == 2'h0)
          cmd_q <= shift_in;
        if (wbyte_q == 2'h1)
          msb_q <= shift_in;
        // Bytes past the third are acknowledged and dropped.
        if (wbyte_q != 2'h3)
          wbyte_q <= wbyte_q + 2'h1;
      end
      if (state_q == dac_ctrl_pkg::LINK_RD_ACK && scl_rise)
        ack_q <= ~sda_s;                                    // [R3]
    end
  end

  // Open-drain data drive: acknowledge slots and zero bits of read data.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_oe_q  <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
      if (state_d == dac_ctrl_pkg::LINK_ADDR_ACK || state_d == dac_ctrl_pkg::LINK_WR_ACK)
        sda_oe_q <= 1'b1;                                   // [R1] [R2] [R18]
      else if (state_d == dac_ctrl_pkg::LINK_RD_BYTE)
        sda_oe_q <= load_rd ? ~rd_byte[7] : ~shift_d7;
      else
        sda_oe_q <= 1'b0;
    end
  end

  assign shift_d7 = (in_tx && scl_fall) ? shift_q[6] : shift_q[7];

  assign sda_out = sda_out_q;
  assign sda_oe  = sda_oe_q;

  // ---------------------------------------------------------------------
  // Readback pointer
  // ---------------------------------------------------------------------
  // A channel field above seven selects several channels, so start at zero.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr_q   <= 3'h0;
      rd_half_q  <= 1'b0;
      rb_armed_q <= 1'b0;
    end else if (rb_set) begin
      rd_ptr_q   <= shift_in[3] ? 3'h0 : shift_in[2:0];      // [R4]
      rd_half_q  <= 1'b0;
      rb_armed_q <= 1'b1;                                   // [R20]
    end else if (commit) begin
      rb_armed_q <= 1'b0;
    end else if (rd_ack_ok) begin
      rd_half_q <= ~rd_half_q;
      if (rd_half_q)
        rd_ptr_q <= rd_ptr_q + 3'h1;                        // [R5] [R6]
    end
  end

  // ---------------------------------------------------------------------
  // Command execution at the end of the frame
  // ---------------------------------------------------------------------
  logic is_wr_in;
  logic is_update;
  logic is_wr_upd;
  logic chan_ok;

  assign chan_ok   = ~cmd_chan[3];
  assign is_wr_in  = commit && (cmd_code == `CMD_WRITE_INPUT) && chan_ok;
  assign is_update = commit && (cmd_code == `CMD_UPDATE_DAC);
  assign is_wr_upd = commit && (cmd_code == `CMD_WRITE_UPDATE) && chan_ok;

  // Strobe low makes the input register transparent for every channel,
  // mask or not, so the DAC write path only checks the pin level.
  assign bank_bus.wr_ch   = cmd_chan[2:0];
  assign bank_bus.wr_data = frame_data;
  assign bank_bus.wr_in   = is_wr_in | is_wr_upd;            // [R11] [R13]
  assign bank_bus.wr_dac  = (is_wr_in & ~strobe_n_s) | is_wr_upd; // [R10] [R13] [R17]
  assign bank_bus.xfer    = (is_update ? frame_data[7:0] : 8'h00)  // [R12] [R21]
                          | (strobe_fall ? ~mask_q : 8'h00);       // [R11] [R15] [R16]
  assign bank_bus.rd_ch   = rd_ptr_q;

  // Mask and power registers; address field ignored for both.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_q  <= `MASK_RESET;                               // [R22]
      power_q <= `POWER_RESET;                              // [R22]
    end else if (commit) begin
      if (cmd_code == `CMD_STROBE_MASK)
        mask_q <= frame_data[7:0];                          // [R14]
      if (cmd_code == `CMD_POWER_MODE)
        power_q <= frame_data;                              // [R7] [R8]
    end
  end

  assign power_modes = power_q;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_mask_load: assert property (commit && cmd_code == `CMD_STROBE_MASK  // [R14]
    |=> mask_q == $past(frame_data[7:0]))
    else $error("Mask register did not take the low data byte.");
  a_power_load: assert property (commit && cmd_code == `CMD_POWER_MODE  // [R7]
    |=> power_q == $past(frame_data))
    else $error("Power modes did not take the frame data.");
  a_strobe_xfer: assert property (strobe_fall                          // [R16]
    |-> (bank_bus.xfer & ~mask_q) == ~mask_q)
    else $error("Strobe fall missed an unmasked channel.");
  a_masked_hold: assert property (strobe_fall && !is_update           // [R15]
    |-> (bank_bus.xfer & mask_q) == 8'h00)
    else $error("Masked channel followed the strobe.");
  a_imm_update: assert property (is_wr_in && !strobe_n_s               // [R10]
    |-> bank_bus.wr_in && bank_bus.wr_dac)
    else $error("Strobe low write did not reach the DAC register.");
  a_defer_update: assert property (is_wr_in && strobe_n_s              // [R11]
    |-> bank_bus.wr_in && !bank_bus.wr_dac)
    else $error("Strobe high write changed the DAC register.");
  a_update_only: assert property (is_update                            // [R12]
    |-> !bank_bus.wr_in && !bank_bus.wr_dac)
    else $error("Update command wrote an input register.");
  a_ptr_wrap: assert property (rd_ack_ok && rd_half_q && rd_ptr_q == 3'h7 && !rb_set // [R6]
    |=> rd_ptr_q == 3'h0)
    else $error("Read pointer did not wrap to zero.");
  a_multi_sel: assert property (rb_set && shift_in[3]                  // [R4]
    |=> rd_ptr_q == 3'h0 ##1 rd_ptr_q == 3'h0)
    else $error("Multi-channel readback did not select channel zero.");

endmodule

`default_nettype wire

//--- tb/i2c_master_model.sv
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------------
// Two-wire bus master, one bit every 40 mclk (160 ns)
// ---------------------------------------------------------------------
module i2c_master_model (
  // Clock
  input  wire logic mclk,
  // Bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  // Both lines rest high, so SCL stands still between frames.
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // A quarter of a bit period.
  task automatic qtr();
    repeat (10) @(posedge mclk);
  endtask

  // Start or repeated start: SDA falls while SCL is high.
  task automatic start_c();
    sda_pull <= 1'b0;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_pull <= 1'b1;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask

  // Data changes only while SCL is low and is sampled mid-high.
  task automatic bit_c(input logic b, output logic s);
    sda_pull <= ~b;
    qtr();
    scl <= 1'b1;
    qtr();
    s = sda_line;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask

  // Byte out MSB first; the ninth clock returns the device's answer.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], s);
    end
    bit_c(1'b1, s);
    ack = ~s;
  endtask

  // Byte in; a NACK on the last byte ends the read.
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, s);
      d[i] = s;
    end
    bit_c(~ack, s);
  endtask

  // Stop: SDA rises while SCL is high.
  task automatic stop_c();
    sda_pull <= 1'b1;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_pull <= 1'b0;
    qtr();
  endtask
endmodule

`default_nettype wire

//--- tb/dac_readback_powerdown_load_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none

module dac_readback_powerdown_load_ctrl_test;
  // ---------------------------------------------------------------------
  // Pins, expected state and counters
  // ---------------------------------------------------------------------
  logic         mclk          = 1'b0;
  logic         sys_rst       = 1'b1;
  logic [1:0]   addr_strap    = 2'h2;
  logic         load_strobe_n = 1'b1;
  logic         scl;
  logic         sda_pull;
  logic         sda_oe;
  logic         sda_out;
  wire  logic   sda_line;
  logic [127:0] dac_value;
  logic [15:0]  power_modes;
  logic [15:0]  in_m [8];
  logic [15:0]  dac_m [8];
  logic [15:0]  pm_m          = 16'h0000;
  logic [7:0]   mask_m        = 8'h00;
  logic [31:0]  seed          = 32'h91C8;
  int           n_fail        = 0;
  int           checked       = 0;

  // Half period of 2 ns gives 250 MHz.
  always #2 mclk = ~mclk;

  // Open-drain data line with a pull-up.
  assign sda_line = ~(sda_oe | sda_pull);

  dac_link_ctrl u_dut (
    .mclk          (mclk),
    .sys_rst       (sys_rst),
    .scl_in        (scl),
    .sda_in        (sda_line),
    .sda_out       (sda_out),
    .sda_oe        (sda_oe),
    .addr_strap    (addr_strap),
    .load_strobe_n (load_strobe_n),
    .dac_value     (dac_value),
    .power_modes   (power_modes)
  );

  i2c_master_model u_m (
    .mclk     (mclk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_pull (sda_pull)
  );

  function automatic logic [31:0] nxt(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic logic [127:0] exp_dac();
    logic [127:0] v;
    for (int i = 0; i < 8; i++) begin
      v[16*i +: 16] = dac_m[i];
    end
    return v;
  endfunction

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic frame(input logic [6:0] adr, input logic [23:0] w, output logic ok);
    logic [3:0] a;
    u_m.start_c();
    u_m.wr_byte({adr, 1'b0}, a[0]);
    u_m.wr_byte(w[23:16], a[1]);
    u_m.wr_byte(w[15:8], a[2]);
    u_m.wr_byte(w[7:0], a[3]);
    u_m.stop_c();
    ok = &a;
    repeat (8) @(posedge mclk);
  endtask

  // Send one command frame and apply its effect to the expected state.
  task automatic wrc(input logic [3:0] cmd, input logic [3:0] ch, input logic [15:0] d);
    logic ok;
    frame({5'h03, addr_strap}, {cmd, ch, d}, ok);
    check("write acks", ok, 1'b1);
    // A channel field above seven is refused by the single-channel writes.
    if ((cmd == 4'h1 || cmd == 4'h3) && !ch[3]) begin
      in_m[ch[2:0]] = d;
    end
    if (!ch[3] && (cmd == 4'h3 || (cmd == 4'h1 && !load_strobe_n))) begin
      dac_m[ch[2:0]] = d;
    end
    for (int i = 0; i < 8; i++) begin
      if (cmd == 4'h2 && d[i]) begin
        dac_m[i] = in_m[i];
      end
    end
    if (cmd == 4'h4) begin
      pm_m = d;
    end
    if (cmd == 4'h5) begin
      mask_m = d[7:0];
    end
    check("dac_value", dac_value, exp_dac());
    check("power_modes", power_modes, pm_m);
  endtask

  // Falling strobe copies every unmasked channel; the pin returns high 10 cycles later.
  task automatic strobe_fall();
    @(posedge mclk);
    load_strobe_n <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (!mask_m[i]) begin
        dac_m[i] = in_m[i];
      end
    end
    repeat (10) @(posedge mclk);
    check("strobe transfer", dac_value, exp_dac());
    load_strobe_n <= 1'b1;
    repeat (10) @(posedge mclk);
  endtask

  // Arm readback at a channel, then read pairs, the last byte NACKed.
  task automatic rb(input logic [3:0] ch, input int pairs);
    logic [2:0] a;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [2:0] p;
    p = ch[3] ? 3'h0 : ch[2:0];
    u_m.start_c();
    u_m.wr_byte({5'h03, addr_strap, 1'b0}, a[0]);
    u_m.wr_byte({4'h9, ch}, a[1]);
    u_m.start_c();
    u_m.wr_byte({5'h03, addr_strap, 1'b1}, a[2]);
    check("read acks", a, 3'h7);
    for (int k = 0; k < pairs; k++) begin
      u_m.rd_byte(1'b1, hi);
      u_m.rd_byte(k < pairs - 1, lo);
      check("readback", {hi, lo}, in_m[p]);
      p = p + 3'h1;
    end
    u_m.stop_c();
    repeat (8) @(posedge mclk);
  endtask

  // Cut a hang short well past the expected run of about 49400 cycles.
  initial begin
    repeat (95000) @(posedge mclk);
    n_fail++;
    $display("watchdog expired");
    give_verdict();
  end

  // Main sequence: random data with hand-picked corners.
  initial begin
    logic        ok;
    logic [1:0]  m;
    logic [15:0] pm;
    for (int i = 0; i < 8; i++) begin
      in_m[i] = 16'h0000;
      dac_m[i] = 16'h0000;
    end
    seed = nxt(seed);
    addr_strap <= seed[1:0];
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    check("power reset", power_modes, 16'h0000);
    check("sda drive value", sda_out, 1'b0);
    frame({5'h03, ~addr_strap}, 24'h30FFFF, ok);
    check("foreign address", ok, 1'b0);
    $display("test reset_address done");
    for (int i = 0; i < 8; i++) begin
      seed = nxt(seed);
      wrc(4'h3, i[3:0], seed[15:0]);
    end
    for (int i = 0; i < 4; i++) begin
      seed = nxt(seed);
      wrc(4'h1, {1'b0, seed[18:16]}, seed[15:0]);
    end
    strobe_fall();
    $display("test direct_deferred done");
    seed = nxt(seed);
    wrc(4'h5, seed[27:24], seed[15:0]);
    for (int i = 0; i < 4; i++) begin
      seed = nxt(seed);
      wrc(4'h1, {1'b0, seed[18:16]}, seed[15:0]);
    end
    rb(4'h6, 3);
    rb(4'hC, 1);
    strobe_fall();
    seed = nxt(seed);
    wrc(4'h2, seed[19:16], {seed[15:8], seed[7:0]});
    $display("test mask_readback_update done");
    for (int j = 0; j < 4; j++) begin
      seed = nxt(seed);
      for (int c = 0; c < 8; c++) begin
        m = (j < 3) ? j[1:0] : seed[2*c +: 2];
        pm[2*c +: 2] = (m == 2'h2) ? 2'h3 : m;
      end
      wrc(4'h4, seed[19:16], pm);
    end
    wrc(4'h3, 4'h5, 16'hFFFF);
    wrc(4'h3, 4'hD, 16'h5A5A);
    $display("test power done");
    wrc(4'h5, 4'h0, 16'h00FF);
    @(posedge mclk);
    load_strobe_n <= 1'b0;
    repeat (10) @(posedge mclk);
    check("all masked", dac_value, exp_dac());
    for (int i = 0; i < 3; i++) begin
      seed = nxt(seed);
      wrc(4'h1, {1'b0, seed[18:16]}, seed[15:0]);
    end
    load_strobe_n <= 1'b1;
    $display("test strobe_low done");
    give_verdict();
  end
endmodule

`default_nettype wire
